// ---- include/isar_bus.sv ----
// Purpose: wired-and two-wire bus joining slave and master
// Assumes: a pin is pulled low when its enable is high and its output low
// Notes:   line levels are resolved here, not in the ends
`timescale 1ns/1ps
`default_nettype none
interface isar_bus;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl_line;
  logic sda_line;

  assign scl_line = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda_line = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev  (input scl_line, sda_line, output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe);
  modport host (input scl_line, sda_line, output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : isar_bus
`default_nettype wire

// ---- include/isar_pkg.sv ----
// Purpose: shared constants and types for the two-wire slave and its bus master
// Assumes: 125 MHz system clock on both ends
// Notes:   register indices of the slave, byte offsets of the master
package isar_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          QUARTER_NS      = 2500;
  localparam int          QUARTER_CYC     = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  ////////////////////////////////////////////////////////////////////////////
  // slave register indices on its own register port
  localparam logic [2:0]  REG_BUFFER      = 3'h0;
  localparam logic [2:0]  REG_CONTROL_ONE = 3'h1;
  localparam logic [2:0]  REG_STATUS      = 3'h2;
  localparam logic [2:0]  REG_OWN_ADDRESS = 3'h3;
  localparam logic [2:0]  REG_IRQ         = 3'h4;
  // serial_control_one fields
  localparam int          CTL_OV          = 6;
  localparam int          CTL_EN          = 5;
  localparam int          CTL_REL         = 4;
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  // serial_status fields
  localparam int          ST_DA           = 5;
  localparam int          ST_P            = 4;
  localparam int          ST_S            = 3;
  localparam int          ST_RW           = 2;
  localparam int          ST_UA           = 1;
  localparam int          ST_BF           = 0;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  // mode_select codes
  localparam logic [3:0]  MODE_MASTER     = 4'h8;
  localparam logic [3:0]  MODE_SLV7       = 4'h6;
  localparam logic [3:0]  MODE_SLV10      = 4'h7;
  localparam logic [3:0]  MODE_FW_MASTER  = 4'hB;
  localparam logic [3:0]  MODE_SLV7_SP    = 4'hE;
  localparam logic [3:0]  MODE_SLV10_SP   = 4'hF;
  localparam logic [4:0]  TEN_BIT_HEAD    = 5'h1E;
  ////////////////////////////////////////////////////////////////////////////
  // master wishbone byte offsets
  localparam logic [3:0]  WB_CMD          = 4'h0;
  localparam logic [3:0]  WB_TXD          = 4'h4;
  localparam logic [3:0]  WB_RXD          = 4'h8;
  localparam logic [3:0]  WB_STAT         = 4'hC;

  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_START = 3'b001,
    CMD_STOP  = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_READ  = 3'b100
  } isar_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RX    = 3'b001,
    S_ACK   = 3'b010,
    S_TX    = 3'b011,
    S_TXACK = 3'b100,
    S_SKIP  = 3'b101
  } isar_state_t;

  typedef enum logic [1:0] {
    K_FIRST  = 2'b00,
    K_SECOND = 2'b01,
    K_DATA   = 2'b10
  } isar_kind_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_STOP  = 2'b10,
    H_BIT   = 2'b11
  } isar_hstate_t;
endpackage : isar_pkg

// ---- logic/isar_device.sv ----
// Purpose: two-wire slave port with 7/10-bit addressing, receive and transmit
// Assumes: bus pins synchronous to clock; master modes leave the slave idle
// Notes:   registers reached through reg_addr/reg_wr/reg_rd
`timescale 1ns/1ps
`default_nettype none
module isar_device import isar_pkg::*; (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // two-wire bus
  isar_bus.dev             bus,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // pin_direction: bit1 data, bit0 clock, high = input
  input  wire logic [1:0]  pin_direction,
  // interrupt flag
  output logic             port_irq_flag
);
  ////////////////////////////////////////////////////////////////////////////
  isar_state_t state_r;
  isar_kind_t  kind_r;
  logic [3:0]  mode_r;
  logic        en_r, rel_r, ov_r, bf_r, ua_r, rw_r, da_r, p_r, s_r, irq_r;
  logic        ten_ok_r, nack_r, read_r;
  logic [7:0]  own_r, buf_r, sr_r;
  logic [3:0]  cnt_r;
  logic        scl_q, sda_q;
  logic        slave_on, ten_mode, sp_mode, i2c_on;
  logic        rise, fall, start_ev, stop_ev, byte_end;
  logic        take, rd_dir, set_ua, ten_done, ev_load, ev_ov;
  isar_kind_t  kind_nxt;
  logic        buf_rd, own_wr, buf_wr, ctl_wr, irq_wr;

  function automatic logic addr_eq(input logic [7:0] sr, input logic [7:0] own);
    addr_eq = (sr[7:1] == own[7:1]);
  endfunction : addr_eq

  assign ten_mode = (mode_r == MODE_SLV10) || (mode_r == MODE_SLV10_SP);
  assign sp_mode  = (mode_r == MODE_SLV7_SP) || (mode_r == MODE_SLV10_SP);
  assign slave_on = en_r && (ten_mode || sp_mode || mode_r == MODE_SLV7);
  assign i2c_on   = en_r && (slave_on || mode_r == MODE_MASTER || mode_r == MODE_FW_MASTER);

  assign buf_rd = reg_rd && reg_addr == REG_BUFFER;
  assign buf_wr = reg_wr && reg_addr == REG_BUFFER;
  assign ctl_wr = reg_wr && reg_addr == REG_CONTROL_ONE;
  assign own_wr = reg_wr && reg_addr == REG_OWN_ADDRESS;
  assign irq_wr = reg_wr && reg_addr == REG_IRQ;

  ////////////////////////////////////////////////////////////////////////////
  // bus sampling and conditions
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl_line;
      sda_q <= bus.sda_line;
    end
  end

  assign rise     = bus.scl_line & ~scl_q;
  assign fall     = ~bus.scl_line & scl_q;
  assign start_ev = slave_on && bus.scl_line && scl_q && sda_q && !bus.sda_line;
  assign stop_ev  = slave_on && bus.scl_line && scl_q && !sda_q && bus.sda_line;
  assign byte_end = state_r == S_RX && fall && cnt_r == 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // address decision at the eighth falling clock
  always_comb begin
    take     = 1'b0;
    rd_dir   = 1'b0;
    set_ua   = 1'b0;
    ten_done = 1'b0;
    kind_nxt = kind_r;
    if (byte_end) begin
      unique case (kind_r)
        K_FIRST: begin
          if (!ten_mode) begin
            take     = addr_eq(sr_r, own_r);
            rd_dir   = sr_r[0];
            kind_nxt = K_DATA;
          end else if (sr_r[7:3] == TEN_BIT_HEAD && addr_eq(sr_r, own_r)) begin
            take   = !sr_r[0] || ten_ok_r;
            rd_dir = sr_r[0];
            set_ua = !sr_r[0];
            kind_nxt = sr_r[0] ? K_DATA : K_SECOND;
          end
        end
        K_SECOND: begin
          take     = (sr_r == own_r);
          set_ua   = 1'b1;
          ten_done = 1'b1;
          kind_nxt = K_DATA;
        end
        K_DATA: begin
          take = !read_r;
        end
        default: begin
          take = 1'b0;
        end
      endcase
    end
  end

  assign ev_load = take && !(bf_r || ov_r);
  assign ev_ov   = take && bf_r;

  ////////////////////////////////////////////////////////////////////////////
  // protocol sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r  <= S_IDLE;
      kind_r   <= K_FIRST;
      cnt_r    <= 4'h0;
      sr_r     <= 8'h00;
      ten_ok_r <= 1'b0;
      nack_r   <= 1'b0;
      read_r   <= 1'b0;
    end else if (!slave_on) begin
      state_r  <= S_IDLE;
      ten_ok_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= S_RX;
      kind_r  <= K_FIRST;
      cnt_r   <= 4'h0;
    end else if (stop_ev) begin
      state_r  <= S_IDLE;
      ten_ok_r <= 1'b0;
    end else begin
      if (buf_wr && !(state_r == S_TX && rel_r))
        sr_r <= reg_wdata;
      unique case (state_r)
        S_IDLE, S_SKIP: begin
          cnt_r <= 4'h0;
        end
        S_RX: begin
          if (rise) begin
            sr_r  <= {sr_r[6:0], bus.sda_line};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            if (take) begin
              state_r  <= S_ACK;
              nack_r   <= !ev_load;
              read_r   <= rd_dir;
              kind_r   <= kind_nxt;
              ten_ok_r <= ten_ok_r | ten_done;
            end else begin
              state_r <= S_SKIP;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            cnt_r <= 4'h0;
            if (nack_r && read_r)
              state_r <= S_SKIP;
            else if (read_r) begin
              state_r <= S_TX;
              sr_r    <= 8'hFF;  // data line released until software loads a byte
            end else
              state_r <= S_RX;  // refused bytes still raise the flag
          end
        end
        S_TX: begin
          if (fall) begin
            sr_r  <= {sr_r[6:0], 1'b1};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h7)
              state_r <= S_TXACK;
          end
        end
        S_TXACK: begin
          if (rise)
            nack_r <= bus.sda_line;
          else if (fall) begin
            state_r <= nack_r ? S_IDLE : S_TX;  // flag still set on ninth fall
            cnt_r   <= 4'h0;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (rst || !slave_on) begin
      bf_r <= 1'b0;
      ua_r <= 1'b0;
      rw_r <= 1'b0;
      da_r <= 1'b0;
      p_r  <= 1'b0;
      s_r  <= 1'b0;
    end else begin
      if (ev_load)
        bf_r <= 1'b1;
      else if (buf_rd || (state_r == S_TXACK && rise && bus.sda_line))
        bf_r <= 1'b0;
      if (byte_end && take && set_ua)
        ua_r <= 1'b1;
      else if (own_wr)
        ua_r <= 1'b0;
      if (byte_end && take && kind_r != K_DATA) begin
        rw_r <= rd_dir;
        da_r <= 1'b0;
      end else if (byte_end && take)
        da_r <= 1'b1;
      if (state_r == S_TXACK && rise && bus.sda_line) begin
        rw_r <= 1'b0;
        da_r <= 1'b0;
      end
      if (start_ev) begin
        s_r <= 1'b1;
        p_r <= 1'b0;
      end else if (stop_ev) begin
        s_r <= 1'b0;
        p_r <= 1'b1;
      end
    end
  end

  // byte completion on the ninth fall, and start/stop in their modes
  always_ff @(posedge clock) begin
    if (rst)
      irq_r <= 1'b0;
    else if ((state_r == S_ACK || state_r == S_TXACK) && fall && slave_on && !start_ev)
      irq_r <= 1'b1;
    else if (sp_mode && (start_ev || stop_ev))
      irq_r <= 1'b1;
    else if (irq_wr && !reg_wdata[0])
      irq_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      en_r   <= CTL_RESET[CTL_EN];
      rel_r  <= CTL_RESET[CTL_REL];
      ov_r   <= CTL_RESET[CTL_OV];
      mode_r <= CTL_RESET[3:0];
      own_r  <= 8'h00;
      buf_r  <= 8'h00;
    end else begin
      if (ctl_wr) begin
        en_r   <= reg_wdata[CTL_EN];
        mode_r <= reg_wdata[3:0];
        rel_r  <= reg_wdata[CTL_REL];
      end else if (state_r == S_ACK && fall && read_r && !nack_r)
        rel_r <= 1'b0;
      else if (state_r == S_TXACK && fall)
        rel_r <= 1'b0;
      if (ev_ov)
        ov_r <= 1'b1;
      else if (ctl_wr && !reg_wdata[CTL_OV])
        ov_r <= 1'b0;
      if (own_wr)
        own_r <= reg_wdata;
      if (ev_load)
        buf_r <= sr_r;
      else if (buf_wr)
        buf_r <= reg_wdata;
    end
  end

  // read data is registered: visible the cycle after reg_rd
  always_ff @(posedge clock) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      unique case (reg_addr)
        REG_BUFFER:      reg_rdata <= buf_r;
        REG_CONTROL_ONE: reg_rdata <= {1'b0, ov_r, en_r, rel_r, mode_r};
        REG_STATUS:      reg_rdata <= {2'b00, da_r, p_r, s_r, rw_r, ua_r, bf_r};
        REG_OWN_ADDRESS: reg_rdata <= own_r;
        REG_IRQ:         reg_rdata <= {7'h00, irq_r};
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pins: only pull low, only when enabled and pins set as inputs
  logic pins_ok, hold_scl, pull_sda;
  assign pins_ok  = i2c_on && (&pin_direction);
  assign hold_scl = (state_r == S_TX && !rel_r) || (state_r == S_RX && cnt_r == 4'h0 && ua_r);
  assign pull_sda = (state_r == S_ACK && !nack_r) || (state_r == S_TX && !sr_r[7]);

  assign bus.dev_scl_o  = 1'b0;
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_scl_oe = pins_ok && slave_on && hold_scl;
  assign bus.dev_sda_oe = pins_ok && slave_on && pull_sda;
  assign port_irq_flag  = irq_r;
endmodule : isar_device
`default_nettype wire

// ---- logic/isar_host.sv ----
// Purpose: bus master end driven by software over classic wishbone
// Assumes: one command at a time; clock stretching honoured
// Notes:   commands issued while busy are ignored
`timescale 1ns/1ps
`default_nettype none
module isar_host import isar_pkg::*; (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // two-wire bus
  isar_bus.host            bus,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [8:0] QTR = 9'(QUARTER_CYC - 1);

  isar_hstate_t hst_r;
  logic [1:0]   ph_r;
  logic [8:0]   tmr_r;
  logic [3:0]   bit_r;
  logic [8:0]   sh_r, rx_r;
  logic [7:0]   txd_r;
  logic         scl_low_r, sda_low_r, nack_r;
  logic         req, wr_cmd, wait_hi;
  isar_cmd_t    cmd;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = req && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_CMD && hst_r == H_IDLE;
  assign cmd    = isar_cmd_t'(wb_dat_i[2:0]);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone: ack one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      txd_r    <= 8'h00;
    end else begin
      wb_ack_o <= req;
      if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_TXD)
        txd_r <= wb_dat_i[7:0];
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          WB_TXD:  wb_dat_o <= {24'h00_0000, txd_r};
          WB_RXD:  wb_dat_o <= {24'h00_0000, rx_r[8:1]};
          WB_STAT: wb_dat_o <= {28'h000_0000, bus.sda_line, bus.scl_line, nack_r,
                                hst_r != H_IDLE};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit engine; a quarter period per phase, stretched while slave holds clock
  assign wait_hi = (hst_r == H_START && ph_r == 2'h0) || (hst_r == H_STOP && ph_r == 2'h1) ||
                   (hst_r == H_BIT && ph_r == 2'h1);

  always_ff @(posedge clock) begin
    if (rst) begin
      hst_r     <= H_IDLE;
      ph_r      <= 2'h0;
      tmr_r     <= 9'h000;
      bit_r     <= 4'h0;
      sh_r      <= 9'h1FF;
      rx_r      <= 9'h000;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      nack_r    <= 1'b0;
    end else if (hst_r == H_IDLE) begin
      ph_r  <= 2'h0;
      tmr_r <= QTR;
      bit_r <= 4'h0;
      if (wr_cmd) begin
        unique case (cmd)
          CMD_START: begin
            hst_r     <= H_START;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
          end
          CMD_STOP: begin
            hst_r     <= H_STOP;
            sda_low_r <= 1'b1;
          end
          CMD_WRITE: begin
            hst_r     <= H_BIT;
            sh_r      <= {txd_r, 1'b1};
            sda_low_r <= !txd_r[7];
          end
          CMD_READ: begin
            hst_r     <= H_BIT;
            sh_r      <= {8'hFF, wb_dat_i[3]};
            sda_low_r <= 1'b0;
          end
          default: begin
            hst_r <= H_IDLE;
          end
        endcase
      end
    end else if (tmr_r != 9'h000) begin
      if (!(wait_hi && !bus.scl_line))
        tmr_r <= tmr_r - 9'h001;
    end else begin
      tmr_r <= QTR;
      ph_r  <= ph_r + 2'h1;
      unique case (hst_r)
        H_START: begin
          if (ph_r == 2'h0)
            sda_low_r <= 1'b1;
          else begin
            scl_low_r <= 1'b1;
            hst_r     <= H_IDLE;
          end
        end
        H_STOP: begin
          if (ph_r == 2'h0)
            scl_low_r <= 1'b0;
          else begin
            sda_low_r <= 1'b0;
            hst_r     <= H_IDLE;
          end
        end
        H_BIT: begin
          if (ph_r == 2'h0)
            scl_low_r <= 1'b0;
          else if (ph_r == 2'h1) begin
            rx_r      <= {rx_r[7:0], bus.sda_line};
            scl_low_r <= 1'b1;
            sh_r      <= {sh_r[7:0], 1'b1};
            bit_r     <= bit_r + 4'h1;
          end else begin
            ph_r <= 2'h0;
            if (bit_r == 4'h9) begin
              nack_r    <= rx_r[0];
              sda_low_r <= 1'b0;
              hst_r     <= H_IDLE;
            end else
              sda_low_r <= !sh_r[8];
          end
        end
        default: begin
          hst_r <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_low_r;
  assign bus.host_sda_oe = sda_low_r;
endmodule : isar_host
`default_nettype wire

// ---- verif/isar_properties.sv ----
// Purpose: wire-level checks of the slave end
// Assumes: one clock, lines sampled each cycle
// Notes:   bit position rebuilt from the lines, not taken from the ends
`timescale 1ns/1ps
`default_nettype none
module isar_properties import isar_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // resolved lines
  input wire logic scl_line,
  input wire logic sda_line,
  // slave drives
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  ////////////////////////////////////////
  logic       scl_q;
  logic       sda_q;
  logic       busy_r;
  logic [3:0] rise_r;
  logic [7:0] low_r;
  wire        start_w = scl_line & scl_q & sda_q & ~sda_line;
  wire        stop_w  = scl_line & scl_q & ~sda_q & sda_line;
  wire        rise_w  = scl_line & ~scl_q;
  wire        fall_w  = ~scl_line & scl_q;
  always_ff @(posedge clock) begin
    scl_q <= scl_line;
    sda_q <= sda_line;
  end
  always_ff @(posedge clock) begin
    if (rst) busy_r <= 1'b0;
    else if (start_w | stop_w) busy_r <= start_w;
  end
  // rises 1..9 per byte; a start restarts the count
  always_ff @(posedge clock) begin
    if (rst | start_w) rise_r <= 4'h0;
    else if (rise_w) rise_r <= (rise_r == 4'h9) ? 4'h1 : rise_r + 4'h1;
  end
  // saturates so a long stretch cannot wrap into a false short gap
  always_ff @(posedge clock) begin
    if (rst | fall_w) low_r <= 8'h00;
    else if (low_r != 8'hFF) low_r <= low_r + 8'h01;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_OPEN_DRAIN:
    assert property (!dev_scl_o && !dev_sda_o)
    else $error("slave drove a line high");
  AST_SDA_MOVES_LOW:
    assert property ($changed(dev_sda_oe) |-> !$past(scl_line))
    else $error("slave data changed while clock high");
  AST_STRETCH_NINTH:
    assert property ($rose(dev_scl_oe) |-> rise_r == 4'h9 && !$past(scl_line))
    else $error("clock held outside the ninth low phase");
  AST_STRETCH_HOLD:
    assert property ($rose(dev_scl_oe) |=> dev_scl_oe [*4])
    else $error("clock hold dropped at once");
  AST_ACK_PROMPT:
    assert property ($rose(dev_sda_oe) && rise_r == 4'h8 |-> low_r <= 8'h04)
    else $error("acknowledge late after eighth fall");
  AST_TX_ON_FALL:
    assert property ($changed(dev_sda_oe) && rise_r inside {[4'h1:4'h7]} |-> low_r <= 8'h04)
    else $error("transmit bit not changed at clock fall");
  AST_ACK_RELEASE:
    assert property (fall_w && rise_r == 4'h9 && dev_sda_oe |-> ##[1:4] !dev_sda_oe)
    else $error("acknowledge not released after ninth fall");
  AST_IDLE_QUIET:
    assert property (!busy_r && !start_w |-> !dev_sda_oe && !dev_scl_oe)
    else $error("slave drove the bus outside a frame");
  cover property ($rose(dev_scl_oe));
  cover property (fall_w && rise_r == 4'h9 && dev_sda_oe);
  cover property (stop_w);
endmodule : isar_properties
`default_nettype wire

// ---- verif/test_i2c_slave_address_receive.sv ----
// Purpose: software-level bench of slave and master on one bus
// Assumes: each byte on the wire costs about 8.5k cycles
// Notes:   slave seen through its register port, master through wishbone
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_address_receive import isar_pkg::*; ;
  ////////////////////////////////////////
  logic        clock;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [31:0] wb_dat;
  logic        wb_ack;
  logic [31:0] rd;
  logic [2:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        irq;
  int          fail_count = 0;
  int          n_compared = 0;
  int          tick = 0;
  ////////////////////////////////////////
  isar_bus isar_bus_i ();
  isar_device isar_device_i (
    .clock(clock), .rst(rst), .bus(isar_bus_i), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pin_direction(2'b11), .port_irq_flag(irq)
  );
  isar_host isar_host_i (
    .clock(clock), .rst(rst), .bus(isar_bus_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack)
  );
  isar_properties isar_properties_i (
    .clock(clock), .rst(rst), .scl_line(isar_bus_i.scl_line),
    .sda_line(isar_bus_i.sda_line), .dev_scl_o(isar_bus_i.dev_scl_o),
    .dev_scl_oe(isar_bus_i.dev_scl_oe), .dev_sda_o(isar_bus_i.dev_sda_o),
    .dev_sda_oe(isar_bus_i.dev_sda_oe)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clock);
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : wb
  // poll busy; the slave may stretch, so no fixed cycle count is assumed
  task automatic hop(input logic [3:0] c, input logic [7:0] t);
    int n;
    n = 0;
    wb(1'b1, WB_TXD, t);
    wb(1'b1, WB_CMD, {4'h0, c});
    do begin
      wb(1'b0, WB_STAT, 8'h00);
      n++;
    end while (rd[0] !== 1'b0 && n < 40000);
  endtask : hop
  task automatic hw(input logic [7:0] t, input logic k);
    hop({1'b0, CMD_WRITE}, t);
    chk({7'h00, rd[1]}, {7'h00, k});
  endtask : hw
  task automatic dwr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : dwr
  task automatic dchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_rdata & m, e);
  endtask : dchk
  task automatic irqchk();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk({7'h00, irq}, 8'h01);
    dwr(REG_IRQ, 8'h00);
  endtask : irqchk
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    tick <= tick + 1;
    if (tick == 100000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h00000000;
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    dchk(REG_CONTROL_ONE, 8'hFF, CTL_RESET);
    dchk(REG_STATUS, 8'hFF, STATUS_RESET);
    dchk(3'h7, 8'hFF, 8'h00);
    // seven-bit write; later bytes refused while full, then while overflowed
    dwr(REG_OWN_ADDRESS, 8'h54);
    dwr(REG_CONTROL_ONE, 8'h26);
    hop({1'b0, CMD_START}, 8'h00);
    hw(8'h54, 1'b0);
    irqchk();
    dchk(REG_IRQ, 8'h01, 8'h00);
    dchk(REG_STATUS, 8'h05, 8'h01);
    hw(8'hC3, 1'b1);
    irqchk();
    dchk(REG_CONTROL_ONE, 8'h40, 8'h40);
    dchk(REG_BUFFER, 8'hFF, 8'h54);
    dchk(REG_STATUS, 8'h01, 8'h00);
    hw(8'h5A, 1'b1);
    irqchk();
    dchk(REG_BUFFER, 8'hFF, 8'h54);
    dwr(REG_CONTROL_ONE, 8'h26);
    dchk(REG_CONTROL_ONE, 8'h40, 8'h00);
    hop({1'b0, CMD_STOP}, 8'h00);
    // seven-bit read: held clock, software loads, master ends with nack
    hop({1'b0, CMD_START}, 8'h00);
    hw(8'h55, 1'b0);
    irqchk();
    dchk(REG_STATUS, 8'h05, 8'h05);
    dchk(REG_BUFFER, 8'hFF, 8'h55);
    dwr(REG_BUFFER, 8'hA7);
    dwr(REG_CONTROL_ONE, 8'h36);
    hop({1'b1, CMD_READ}, 8'h00);
    wb(1'b0, WB_RXD, 8'h00);
    chk(rd[7:0], 8'hA7);
    irqchk();
    dchk(REG_STATUS, 8'h04, 8'h00);
    hop({1'b0, CMD_STOP}, 8'h00);
    // ten-bit write: head byte, address reload, low byte, reload again
    dwr(REG_OWN_ADDRESS, 8'hF4);
    dwr(REG_CONTROL_ONE, 8'h3F);
    hop({1'b0, CMD_START}, 8'h00);
    irqchk();
    hw(8'hF4, 1'b0);
    irqchk();
    dchk(REG_STATUS, 8'h03, 8'h03);
    dchk(REG_BUFFER, 8'hFF, 8'hF4);
    dwr(REG_OWN_ADDRESS, 8'hB5);
    dchk(REG_STATUS, 8'h02, 8'h00);
    hw(8'hB5, 1'b0);
    irqchk();
    dchk(REG_STATUS, 8'h03, 8'h03);
    dwr(REG_OWN_ADDRESS, 8'hF4);
    dchk(REG_STATUS, 8'h02, 8'h00);
    hop({1'b0, CMD_STOP}, 8'h00);
    irqchk();
    dchk(REG_STATUS, 8'h18, 8'h10);
    final_report();
  end
endmodule : test_i2c_slave_address_receive
`default_nettype wire
